// ==== design/pwdt_tick_gen.sv ====
// Prescaler producing one tick per 16 or 128 count-source edges
`timescale 1ns/10ps
`default_nettype none
`include "pwdt_params.svh"
module pwdt_tick_gen (
	input  wire logic clk,        // System clock
	input  wire logic rst_b,      // Async reset, active low
	input  wire logic srcEdge,    // Count-source edge
	input  wire logic enable,     // Prescaler running
	input  wire logic divSel,     // 1: divide by 128
	output logic      tick        // One-cycle tick
);
	logic [`PWDT_PRE_W-1:0] phase;
	logic [`PWDT_PRE_W-1:0] lastVal;
	assign lastVal = divSel ? `PWDT_DIV128_LAST : `PWDT_DIV16_LAST;
	// Phase cleared only by reset or its own wrap at the last value, never by a refresh
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase <= '0;
		end else if (enable && srcEdge) begin
			phase <= (phase[3:0] == 4'hF && !divSel) || phase == lastVal
				? '0 : phase + 7'h01;
		end
	end
	assign tick = enable && srcEdge && (divSel ? phase == lastVal
		: phase[3:0] == 4'hF);
endmodule
`default_nettype wire

// ==== design/pwdt_watchdog.sv ====
// Program watchdog timer top
//
// Notes on behaviour
// - Fifteen-bit counter decrements once per prescaled tick.
// - Protect mode selects low-speed oscillator, otherwise CPU clock.
// - Counter auto-starts after reset or waits for start register write.
// - Reset, underflow, or 00h then FFh refresh reload the counter.
// - Stop and wait halt counting only without protect mode.
// - Underflow raises interrupt or reset; protect mode forces reset.
// - Erased option byte reads FFh, all options inactive.
// - Voltage-monitor reset enables latch only at hardware reset.
// - Prescaler divides by 16 or 128 per select bit.
// - Underflow action bit 0 gives interrupt, 1 gives reset.
// - Auto-start option 1 keeps counter stopped, 0 starts it.
// - Refresh reloads counter to 7FFFh but not prescaler phase.
`timescale 1ns/10ps
`default_nettype none
`include "pwdt_params.svh"
module pwdt_watchdog
	import pwdt_pkg::*;
(
	input  wire logic               clk,         // CPU clock, 125 MHz
	input  wire logic               rst_b,       // Async reset, active low
	input  wire logic               hwReset,     // Pulse: hardware reset seen
	input  wire logic               lowOscEdge,  // Low-speed osc edge strobe
	input  wire logic               cpuClkEn,    // CPU clock is running
	input  wire logic               lowPower,    // Stop or wait mode
	input  wire logic               flashErased, // Option block erased
	input  wire logic [7:0]         optionByte,  // Option byte contents
	input  wire pwdt_pkg::pwdt_ctrl_t ctrl,      // Control bits
	input  wire pwdt_pkg::pwdt_wr_t wr,          // Register writes
	output logic [14:0]             count,       // Counter value
	output logic                    running,     // Counter running
	output logic                    wdtIrq,      // Interrupt pulse
	output logic                    wdtReset,    // Reset request pulse
	output logic                    vmon0ResetEn,// Voltage monitor 0 enable
	output logic                    vmon1ResetEn // Voltage monitor 1 enable
);
	import pwdt_pkg::*;
	pwdt_state_t state;
	logic        armed;
	logic        srcEdge;
	logic        tick;
	logic        refresh;
	logic        underflow;
	logic [7:0]  opt;

	// Option bits are active low: 0 enables the feature
	function automatic logic optOn(input logic [7:0] o,
		input int unsigned pos);
		return !o[pos];
	endfunction

	assign opt = flashErased ? `PWDT_ERASED_OPT : optionByte;
	// Protect mode ignores low power; CPU source halts in it
	assign srcEdge = ctrl.protectMode ? lowOscEdge
		: (cpuClkEn && !lowPower);
	assign refresh = wr.refreshWr && armed
		&& wr.refreshData == `PWDT_REFRESH_FIRE;
	assign underflow = tick && count == '0;

	pwdt_tick_gen u_tick (
		.clk     (clk),
		.rst_b   (rst_b),
		.srcEdge (srcEdge),
		.enable  (state == PWDT_RUNNING),
		.divSel  (ctrl.prescalerSelect),
		.tick    (tick)
	);

	// Start state taken one cycle after reset release from option byte
	logic startSampled;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= PWDT_STOPPED;
			startSampled <= 1'b0;
		end else begin
			startSampled <= 1'b1;
			case (state)
			PWDT_STOPPED: begin
				if ((!startSampled && optOn(opt, `PWDT_OPT_AUTOSTART))
					|| wr.startWr) begin
					state <= PWDT_RUNNING;
				end
			end
			PWDT_RUNNING: state <= PWDT_RUNNING;
			default: state <= PWDT_STOPPED;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			armed <= 1'b0;
		end else if (wr.refreshWr) begin
			armed <= wr.refreshData == `PWDT_REFRESH_ARM;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= `PWDT_CNT_RESET;
		end else if (refresh || underflow) begin
			count <= `PWDT_CNT_RESET;
		end else if (tick) begin
			count <= count - 15'h0001;
		end
	end

	// Separate flops per output keep each pulse traceable to one cause
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			running <= 1'b0;
		end else begin
			running <= state == PWDT_RUNNING;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wdtIrq <= 1'b0;
		end else begin
			wdtIrq <= underflow && !ctrl.protectMode
				&& !ctrl.underflowAction;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wdtReset <= 1'b0;
		end else begin
			wdtReset <= underflow && (ctrl.protectMode
				|| ctrl.underflowAction);
		end
	end

	// Enables are 1 when option bit is 0; latched only on hardware reset
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			vmon0ResetEn <= 1'b0;
			vmon1ResetEn <= 1'b0;
		end else if (hwReset) begin
			vmon0ResetEn <= optOn(opt, `PWDT_OPT_VMON0);
			vmon1ResetEn <= optOn(opt, `PWDT_OPT_VMON1);
		end
	end

	// One clock domain: all checks share clock and reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	a_underflow_reset: assert property (
		underflow && ctrl.protectMode |=> wdtReset && !wdtIrq)
		else $error("protect mode underflow not reset");
	a_underflow_irq: assert property (
		underflow && !ctrl.protectMode && !ctrl.underflowAction |=> wdtIrq)
		else $error("underflow interrupt missing");
	a_count_reload: assert property (
		refresh |=> count == `PWDT_CNT_RESET)
		else $error("refresh did not reload");
	a_count_decr: assert property (
		tick && count != '0 && !refresh |=> count == $past(count) - 1)
		else $error("counter not decremented");
	a_halt_lowpower: assert property (
		lowPower && !ctrl.protectMode |-> !tick)
		else $error("tick in low power");
	a_stop_hold: assert property (
		state == PWDT_STOPPED |-> !tick)
		else $error("tick while stopped");
	a_start_write: assert property (
		wr.startWr |=> state == PWDT_RUNNING ##1 running)
		else $error("start write ignored");
	a_vmon_hold: assert property (
		!hwReset |=> $stable(vmon0ResetEn) && $stable(vmon1ResetEn))
		else $error("voltage monitor enable changed");

	a_irq_reset_excl: assert property (
		!(wdtIrq && wdtReset))
		else $error("interrupt and reset together");
	a_irq_single: assert property (
		wdtIrq |=> !wdtIrq)
		else $error("interrupt pulse too long");
	a_reset_single: assert property (
		wdtReset |=> !wdtReset)
		else $error("reset pulse too long");
	a_underflow_reload: assert property (
		underflow |=> count == `PWDT_CNT_RESET)
		else $error("underflow did not reload");
	a_erased_opt: assert property (
		flashErased |-> opt == `PWDT_ERASED_OPT)
		else $error("erased option not all ones");
	a_stopped_count: assert property (
		state == PWDT_STOPPED && !refresh |=> $stable(count))
		else $error("count moved while stopped");

	a_refresh_arm: assert property (
		wr.refreshWr && wr.refreshData == `PWDT_REFRESH_ARM |=> armed)
		else $error("refresh not armed");
	a_refresh_disarm: assert property (
		wr.refreshWr && wr.refreshData != `PWDT_REFRESH_ARM |=> !armed)
		else $error("refresh stayed armed");
	a_protect_source: assert property (
		ctrl.protectMode && !lowOscEdge |-> !tick)
		else $error("tick without low-speed edge");
	a_vmon_latch: assert property (
		hwReset |=> vmon0ResetEn == !$past(opt[`PWDT_OPT_VMON0])
		&& vmon1ResetEn == !$past(opt[`PWDT_OPT_VMON1]))
		else $error("voltage monitor enable not latched");
	a_reset_action: assert property (
		wdtReset |-> $past(ctrl.protectMode || ctrl.underflowAction))
		else $error("reset without reset action");
	a_running_state: assert property (
		running == $past(state == PWDT_RUNNING))
		else $error("running flag disagrees with state");

	c_refresh: cover property (refresh);
	c_underflow: cover property (underflow);
	c_start: cover property (wr.startWr);
	c_protect_tick: cover property (tick && ctrl.protectMode);
	c_vmon_latch: cover property (hwReset && !flashErased);
endmodule
`default_nettype wire

// ==== pkg/pwdt_params.svh ====
// Constants for the program watchdog timer
`ifndef PWDT_PARAMS_SVH
`define PWDT_PARAMS_SVH
`define PWDT_CNT_W        15
`define PWDT_CNT_RESET    15'h7FFF
`define PWDT_PRE_W        7
`define PWDT_DIV16_LAST   7'h0F
`define PWDT_DIV128_LAST  7'h7F
`define PWDT_REFRESH_ARM  8'h00
`define PWDT_REFRESH_FIRE 8'hFF
`define PWDT_ERASED_OPT   8'hFF
`define PWDT_OPT_AUTOSTART 0
`define PWDT_OPT_VMON0    2
`define PWDT_OPT_VMON1    3
`endif

// ==== pkg/pwdt_pkg.sv ====
// Types shared by the program watchdog timer
package pwdt_pkg;
	typedef struct packed {
		logic       prescalerSelect; // 1: divide by 128
		logic       underflowAction; // 1: reset, 0: interrupt
		logic       protectMode;     // Low-speed source, always reset
	} pwdt_ctrl_t;
	typedef struct packed {
		logic       refreshWr;
		logic [7:0] refreshData;
		logic       startWr;
	} pwdt_wr_t;
	typedef enum logic [1:0] {PWDT_STOPPED, PWDT_RUNNING} pwdt_state_t;
endpackage

// ==== tb/tb_top.sv ====
// Self-checking bench for the program watchdog timer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import pwdt_pkg::*;
	logic        clk = 1'b0, rst_b = 1'b0, hwReset = 1'b0;
	logic        lowOscEdge = 1'b0, cpuClkEn = 1'b1, lowPower = 1'b0;
	logic        flashErased = 1'b0;
	logic [7:0]  optionByte = 8'h00, d;
	pwdt_ctrl_t  ctrl = '0;
	pwdt_wr_t    wr = '0;
	logic [14:0] count, snap;
	logic        running, wdtIrq, wdtReset, vmon0ResetEn, vmon1ResetEn;
	int          failures = 0, checks_done = 0, n;
	integer      seed = 32'hB2B24396;
	pwdt_watchdog uut (.clk(clk), .rst_b(rst_b), .hwReset(hwReset),
		.lowOscEdge(lowOscEdge), .cpuClkEn(cpuClkEn), .lowPower(lowPower),
		.flashErased(flashErased), .optionByte(optionByte), .ctrl(ctrl),
		.wr(wr), .count(count), .running(running), .wdtIrq(wdtIrq),
		.wdtReset(wdtReset), .vmon0ResetEn(vmon0ResetEn),
		.vmon1ResetEn(vmon1ResetEn));
	always #4 clk = ~clk;
	// Slow source edge every other cycle, only while protected
	always @(posedge clk) lowOscEdge <= ctrl.protectMode & ~lowOscEdge;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task refresh(input logic [7:0] v);
		@(posedge clk) wr <= '{refreshWr: 1'b1, refreshData: v, startWr: 1'b0};
		@(posedge clk) wr <= '0;
		@(posedge clk) #1;
	endtask
	// Cycles between two count steps; first step skipped for phase
	task period(output int c);
		logic [14:0] s;
		c = 0;
		s = count;
		repeat (300) begin @(posedge clk); #1; if (count !== s) break; end
		s = count;
		repeat (300) begin @(posedge clk); #1; c++; if (count !== s) break; end
	endtask
	task do_reset(input logic [7:0] opt);
		@(posedge clk) rst_b <= 1'b0;
		optionByte <= opt;
		repeat (10) @(posedge clk);
		chk(count, 15'h7FFF);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
	endtask
	task pulse_hw;
		@(posedge clk) hwReset <= 1'b1;
		@(posedge clk) hwReset <= 1'b0;
		@(posedge clk) #1;
	endtask
	task wrap_up;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	initial begin
		#200000;
		failures++;
		wrap_up();
	end
	initial begin
		do_reset(8'h00);
		chk(running, 1'b1);
		period(n); chk(n, 16);
		chk({wdtIrq, wdtReset}, 2'b00);
		@(posedge clk) ctrl.prescalerSelect <= 1'b1;
		period(n); chk(n, 128);
		@(posedge clk) ctrl.prescalerSelect <= 1'b0;
		refresh(8'h00); refresh(8'hFF); chk(count > 15'h7FFD, 1'b1);
		period(n); period(n);
		refresh(8'hFF); chk(count !== 15'h7FFF, 1'b1);
		d = 8'($random(seed));
		if (d == 8'h00 || d == 8'hFF) d = 8'h5A;
		refresh(8'h00); refresh(d); refresh(8'hFF);
		chk(count !== 15'h7FFF, 1'b1);
		@(posedge clk) lowPower <= 1'b1;
		@(posedge clk) #1 snap = count;
		repeat (64) @(posedge clk);
		#1 chk(count, snap);
		@(posedge clk) ctrl.protectMode <= 1'b1;
		cpuClkEn <= 1'b0;
		period(n); chk(n, 32);
		@(posedge clk) ctrl.protectMode <= 1'b0;
		cpuClkEn <= 1'b1;
		lowPower <= 1'b0;
		optionByte <= 8'hF3;
		pulse_hw(); chk({vmon1ResetEn, vmon0ResetEn}, 2'b11);
		@(posedge clk) optionByte <= 8'hFF;
		repeat (3) @(posedge clk);
		#1 chk({vmon1ResetEn, vmon0ResetEn}, 2'b11);
		@(posedge clk) flashErased <= 1'b1;
		optionByte <= 8'h00;
		pulse_hw(); chk({vmon1ResetEn, vmon0ResetEn}, 2'b00);
		@(posedge clk) flashErased <= 1'b0;
		do_reset(8'($random(seed)) | 8'h01);
		repeat (40) @(posedge clk);
		#1 chk({running, count}, {1'b0, 15'h7FFF});
		@(posedge clk) wr.startWr <= 1'b1;
		@(posedge clk) wr.startWr <= 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(running, 1'b1);
		wrap_up();
	end
endmodule
`default_nettype wire
